// ---- can_timing_defines.vh ----
// Constants for the protocol core timing and mode control block
`ifndef CAN_TIMING_DEFINES_VH
`define CAN_TIMING_DEFINES_VH
// Register byte offsets within the register window
`define OFS_COMMAND 12'h270
`define OFS_STATUS 12'h271
`define OFS_TIMING 12'h272
// Reset values
`define RST_COMMAND 8'h01
`define RST_STATUS 8'h00
`define RST_TIMING 16'h0000
// Timing register fields
`define PRESC_MSB 5
`define PRESC_LSB 0
`define JUMP_MSB 7
`define JUMP_LSB 6
`define SEG1_MSB 11
`define SEG1_LSB 8
`define SEG2_MSB 14
`define SEG2_LSB 12
`define TRIPLE_BIT 15
// Command register bits
`define CMD_RESET_REQ 0
`define CMD_PAD_DRIVE 2
`define CMD_SLEEP_EN 3
`define CMD_LISTEN 5
`define CMD_SELF_CHECK 6
`define CMD_RX_POL 7
// Status register bits
`define ST_SLEEP_READY 2
`define ST_RX_STATUS 3
`define ST_TX_STATUS 4
`define ST_WARNING 5
`define ST_PASSIVE 6
`define ST_BUS_OFF 7
`endif

// ---- can_core_timing_and_mode_control.v ----
// Protocol core bit timing, mode control, command and status registers
`timescale 1ns/1ps
// Notes on behaviour
// - Quantum is two clocks times prescaler plus one
// - Sample select: one or three samples
// - Sync one quantum; segment one field plus one
// - Segment two field plus one; sample between
// - Resync moves edge at most jump width
// - Resynchronize on recessive-to-dominant edges outside the sync segment
// - Timing register zero, word, reset mode writes
// - Hardware reset leaves core in reset mode
// - Clearing reset request enters operation mode
// - Underflow, bus-off, test mode force reset mode
// - Command resets to 01h, hardware sets bit0
// - Command bit 7 receive polarity, reset mode
// - Status read only, resets 00h, hardware owned; bit 2 reads 1 after reset unless an irq is pending
// - Status bits report core conditions and sleep
`include "can_timing_defines.vh"
module can_core_timing_and_mode_control
(
	// Clock and reset
	input wire mclk,
	input wire srst,
	// Register port
	input wire [11:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire reg_word,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	// Events from the rest of the protocol core
	input wire tx_buffer_underflow,
	input wire bus_off_enter,
	input wire test_mode_enter,
	input wire bus_off_flag,
	input wire error_passive_flag,
	input wire error_warning_flag,
	input wire transmit_status,
	input wire receive_status,
	input wire core_irq_pending,
	input wire hard_sync_en,
	// Bus pin
	input wire can_rx_pin,
	// Core outputs
	output wire op_mode,
	output wire self_check,
	output wire listen_only,
	output wire sleep_enable,
	output wire tx_pad_drive,
	output reg quantum_tick,
	output reg sample_strobe,
	output reg sampled_bit,
	output reg bit_start
);
	// ********************************
	// Registers
	// ********************************
	reg [7:0] cmd_reg; // Command register
	reg [15:0] timing_reg; // Bit timing configuration
	reg [5:0] presc_cnt_reg; // Prescaler count
	reg pre_half_reg; // Half of the two-clock prescaler unit
	reg [1:0] seg_reg; // 0 sync, 1 segment one, 2 segment two
	reg [4:0] tq_cnt_reg; // Quanta spent in current segment
	reg [2:0] rx_sync_reg; // Pin synchroniser
	reg rx_last_reg; // Last accepted bus level
	reg [1:0] early_reg; // Two early samples for majority
	reg idle_reg; // No bus activity seen recently
	reg edge_pend_reg; // Edge seen between quanta, acted on at next tick
	// Derived fields
	wire [5:0] presc = timing_reg[`PRESC_MSB:`PRESC_LSB];
	wire [4:0] seg1_len = {1'b0, timing_reg[`SEG1_MSB:`SEG1_LSB]} + 5'h01;
	wire [4:0] seg2_len = {2'b00, timing_reg[`SEG2_MSB:`SEG2_LSB]} + 5'h01;
	wire [4:0] jump_width = {3'b000, timing_reg[`JUMP_MSB:`JUMP_LSB]} + 5'h01;
	wire triple = timing_reg[`TRIPLE_BIT];
	wire in_reset = cmd_reg[`CMD_RESET_REQ];
	// Receive level with polarity; changes count once stages 2 and 3 agree
	wire rx_agree = (rx_sync_reg[2] == rx_sync_reg[1]);
	wire rx_level = rx_sync_reg[2] ^ cmd_reg[`CMD_RX_POL];
	wire rx_edge = rx_agree && rx_last_reg && !rx_level;
	assign op_mode = !in_reset;
	assign self_check = cmd_reg[`CMD_SELF_CHECK];
	assign listen_only = cmd_reg[`CMD_LISTEN];
	assign sleep_enable = cmd_reg[`CMD_SLEEP_EN];
	assign tx_pad_drive = cmd_reg[`CMD_PAD_DRIVE];
	// Majority of three, used for triple sampling
	function maj3;
		input a, b, c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction
	// ********************************
	// Register writes and mode control
	// ********************************
	// Command and timing registers
	always @(posedge mclk)
	begin
		if (srst)
		begin
			cmd_reg <= `RST_COMMAND;
			timing_reg <= `RST_TIMING;
		end
		else
		begin
			if (reg_wr && reg_addr == `OFS_COMMAND)
			begin
				cmd_reg[`CMD_RESET_REQ] <= reg_wdata[`CMD_RESET_REQ];
				cmd_reg[`CMD_PAD_DRIVE] <= reg_wdata[`CMD_PAD_DRIVE];
				cmd_reg[`CMD_SLEEP_EN] <= reg_wdata[`CMD_SLEEP_EN];
				cmd_reg[`CMD_LISTEN] <= reg_wdata[`CMD_LISTEN];
				cmd_reg[`CMD_SELF_CHECK] <= reg_wdata[`CMD_SELF_CHECK];
				// polarity writable only in reset mode
				if (in_reset)
					cmd_reg[`CMD_RX_POL] <= reg_wdata[`CMD_RX_POL];
			end
			// events force reset mode from operation mode, where set wins over a clear; in reset mode a clear wins
			if (!in_reset && (tx_buffer_underflow || bus_off_enter ||
				test_mode_enter))
				cmd_reg[`CMD_RESET_REQ] <= 1'b1;
			// word writes in reset mode only
			if (reg_wr && reg_word && in_reset && reg_addr == `OFS_TIMING)
				timing_reg <= reg_wdata;
		end
	end
	// ********************************
	// Register read
	// ********************************
	// Registered read data; reserved bits read zero
	always @(posedge mclk)
	begin
		if (srst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`OFS_COMMAND: reg_rdata <= {8'h00, cmd_reg & 8'hed};
				// status assembled only from hardware state
				// bit layout of the status byte
				`OFS_STATUS: reg_rdata <= {8'h00, bus_off_flag,
					error_passive_flag, error_warning_flag,
					transmit_status, receive_status,
					idle_reg && !core_irq_pending, 2'b00};
				`OFS_TIMING: reg_rdata <= reg_word ? timing_reg : 16'h0000;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end
	// ********************************
	// Quantum prescaler
	// ********************************
	// tick every 2*(prescaler+1) clocks
	always @(posedge mclk)
	begin
		if (srst || in_reset)
		begin
			presc_cnt_reg <= 6'h00;
			pre_half_reg <= 1'b0;
			quantum_tick <= 1'b0;
		end
		else
		begin
			quantum_tick <= 1'b0;
			pre_half_reg <= !pre_half_reg;
			if (pre_half_reg)
			begin
				if (presc_cnt_reg == presc)
				begin
					presc_cnt_reg <= 6'h00;
					quantum_tick <= 1'b1;
				end
				else
					presc_cnt_reg <= presc_cnt_reg + 6'h01;
			end
		end
	end
	// ********************************
	// Receive synchroniser and idle sense
	// ********************************
	// Three stage pin synchroniser
	always @(posedge mclk)
	begin
		if (srst)
		begin
			rx_sync_reg <= 3'b111;
			rx_last_reg <= 1'b1;
			idle_reg <= 1'b1;
		end
		else
		begin
			rx_sync_reg <= {rx_sync_reg[1:0], can_rx_pin};
			if (rx_agree)
				rx_last_reg <= rx_level;
			// Idle while the bus stays recessive at a sample point
			if (sample_strobe)
				idle_reg <= sampled_bit;
		end
	end
	// ********************************
	// Bit segment sequencer
	// ********************************
	// bit = sync + segment one + segment two
	always @(posedge mclk)
	begin
		if (srst || in_reset)
		begin
			seg_reg <= 2'd0;
			tq_cnt_reg <= 5'h00;
			sample_strobe <= 1'b0;
			sampled_bit <= 1'b1;
			bit_start <= 1'b0;
			early_reg <= 2'b11;
			edge_pend_reg <= 1'b0;
		end
		else
		begin
			sample_strobe <= 1'b0;
			bit_start <= 1'b0;
			// Edge lasts one clock; keep it so a tick can still act on it
			edge_pend_reg <= !quantum_tick && (edge_pend_reg || rx_edge);
			if ((rx_edge || edge_pend_reg) && seg_reg != 2'd0 &&
				quantum_tick)
			begin
				if (hard_sync_en)
				begin
					seg_reg <= 2'd1;
					tq_cnt_reg <= 5'h00;
				end
				// late edge lengthens segment one by at most sjw
				else if (seg_reg == 2'd1)
					tq_cnt_reg <= (tq_cnt_reg > jump_width) ?
						tq_cnt_reg - jump_width : 5'h00;
				// early edge shortens segment two by at most sjw
				else if (seg2_len - tq_cnt_reg <= jump_width)
				begin
					seg_reg <= 2'd1;
					tq_cnt_reg <= 5'h00;
					bit_start <= 1'b1;
				end
				else
					tq_cnt_reg <= tq_cnt_reg + jump_width;
			end
			else if (quantum_tick)
			begin
				case (seg_reg)
					2'd0:
					begin
						seg_reg <= 2'd1;
						tq_cnt_reg <= 5'h00;
					end
					// segment one of field plus one quanta
					2'd1:
					begin
						// extra samples at the last two ticks of segment one, sample tick included
						if (tq_cnt_reg + 5'h02 >= seg1_len)
							early_reg <= {early_reg[0], rx_level};
						if (tq_cnt_reg + 5'h01 >= seg1_len)
						begin
							seg_reg <= 2'd2;
							tq_cnt_reg <= 5'h00;
							sample_strobe <= 1'b1;
							sampled_bit <= triple ?
								maj3(early_reg[1], early_reg[0], rx_level) :
								rx_level;
						end
						else
							tq_cnt_reg <= tq_cnt_reg + 5'h01;
					end
					// segment two of field plus one quanta
					2'd2:
					begin
						if (tq_cnt_reg + 5'h01 >= seg2_len)
						begin
							seg_reg <= 2'd0;
							tq_cnt_reg <= 5'h00;
							bit_start <= 1'b1;
						end
						else
							tq_cnt_reg <= tq_cnt_reg + 5'h01;
					end
					default:
					begin
						seg_reg <= 2'd0;
						tq_cnt_reg <= 5'h00;
					end
				endcase
			end
		end
	end
endmodule

// ---- can_core_timing_and_mode_control_asserts.sv ----
// Checker for the timing and mode control block
`timescale 1ns/1ps
module can_core_timing_and_mode_control_asserts
(
	// Clock, reset and register port
	input wire mclk,
	input wire srst,
	input wire [11:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	// Events and core outputs
	input wire tx_buffer_underflow,
	input wire bus_off_enter,
	input wire test_mode_enter,
	input wire op_mode,
	input wire quantum_tick,
	input wire sample_strobe,
	input wire bit_start
);
	// Any event that forces reset mode
	wire ev = tx_buffer_underflow | bus_off_enter | test_mode_enter;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	reset_mode_a: assert property ($fell(srst) |-> !op_mode)
		else $error("operation mode right after reset");
	clear_rr_a: assert property (reg_wr && reg_addr == 12'h270 &&
		!reg_wdata[0] && !ev |=> op_mode)
		else $error("clearing reset request did not start");
	event_reset_a: assert property (ev && op_mode |=> !op_mode)
		else $error("event did not force reset mode");
	idle_tick_a: assert property (!op_mode && !$past(op_mode)
		|-> !quantum_tick)
		else $error("quantum tick in reset mode");
	tick_gap_a: assert property (quantum_tick |=> !quantum_tick)
		else $error("quantum ticks too close");
	strobe_gap_a: assert property (sample_strobe |=>
		!sample_strobe [*3])
		else $error("sample points too close");
	seg_order_a: assert property (bit_start |-> !sample_strobe)
		else $error("sample point on bit boundary");
	cmd_rsvd_a: assert property (reg_rd && reg_addr == 12'h270
		|=> reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0)
		else $error("reserved command bits read high");
	status_low_a: assert property (reg_rd && reg_addr == 12'h271
		|=> reg_rdata[1:0] == 2'b00)
		else $error("unused status bits read high");
	// Main scenarios reached
	cover property ($rose(op_mode));
	cover property (sample_strobe);
	cover property (ev && op_mode);
endmodule

// ---- can_bus_node_model.sv ----
// Bus node model driving the receive line of the core
`timescale 1ns/1ps
module can_bus_node_model
(
	// Clock and bus line
	input wire mclk,
	output reg can_line
);
	// Idle bus is recessive through the termination pull-up
	initial can_line = 1'b1;
	// Dominant stretch; its falling edge is what the core resyncs on
	// resync edge source
	task dominant(input int n);
		begin
			@(posedge mclk);
			#1 can_line = 1'b0;
			repeat (n) @(posedge mclk);
			#1 can_line = 1'b1;
		end
	endtask
endmodule

// ---- can_core_timing_and_mode_control_tb.sv ----
// Self-checking bench for the timing and mode control block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin $display("ERROR %s expected %h seen %h", nm, e, a); n_fail++; end end
module can_core_timing_and_mode_control_tb;
	// Stimulus and observed signals
	reg mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_word = 0;
	reg [11:0] reg_addr = 0;
	reg [15:0] reg_wdata = 0;
	reg [2:0] evt = 0;
	reg [4:0] flags = 0;
	wire [15:0] reg_rdata;
	wire op_mode, self_check, listen_only, sleep_enable, tx_pad_drive;
	wire quantum_tick, sample_strobe, sampled_bit, bit_start, rx;
	wire [2:0] sv = {bit_start, sample_strobe, quantum_tick};
	int n_fail = 0, cmp_count = 0, n, i;
	initial forever #2.5 mclk = ~mclk;
	can_bus_node_model node (.mclk(mclk), .can_line(rx));
	// Irq and hard sync held off: bit timing is judged on resync only
	can_core_timing_and_mode_control uut (.mclk, .srst, .reg_addr,
		.reg_wr, .reg_rd, .reg_word, .reg_wdata, .reg_rdata,
		.tx_buffer_underflow(evt[0]), .bus_off_enter(evt[1]),
		.test_mode_enter(evt[2]), .bus_off_flag(flags[4]),
		.error_passive_flag(flags[3]), .error_warning_flag(flags[2]),
		.transmit_status(flags[1]), .receive_status(flags[0]),
		.core_irq_pending(1'b0), .hard_sync_en(1'b0), .can_rx_pin(rx),
		.op_mode, .self_check, .listen_only, .sleep_enable, .tx_pad_drive,
		.quantum_tick, .sample_strobe, .sampled_bit, .bit_start);
	// Register write, held one edge
	task wr(input [11:0] a, input [15:0] d, input w);
		begin
			@(posedge mclk);
			#1 reg_addr = a;
			reg_wdata = d;
			reg_word = w;
			reg_wr = 1;
			@(posedge mclk);
			#1 reg_wr = 0;
		end
	endtask
	// Register read; data lands at the taking edge
	task rd(input string nm, input [11:0] a, input [15:0] e);
		begin
			@(posedge mclk);
			#1 reg_addr = a;
			reg_word = (a == 12'h272);
			reg_rd = 1;
			@(posedge mclk);
			#1 reg_rd = 0;
			`CHK(nm, e, reg_rdata)
		end
	endtask
	// Clocks from a pulse on one strobe to the next on another
	task gap(input int a, input int b);
		begin
			n = 0;
			do @(posedge mclk) #1; while (sv[a] !== 1'b1);
			do begin @(posedge mclk) #1; n++; end while (sv[b] !== 1'b1 && n < 200);
		end
	endtask
	// Counts, then verdict
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", cmp_count, n_fail);
			if (n_fail == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		#60000;
		n_fail++;
		end_of_test;
	end
	// Main sequence
	initial
	begin
		repeat (3) @(posedge mclk);
		#1 srst = 0;
		rd("cmd", 12'h270, 16'h0001);
		rd("timing", 12'h272, 16'h0000);
		wr(12'h272, 16'h1201, 1);
		wr(12'h272, 16'hffff, 0);
		rd("timing", 12'h272, 16'h1201);
		wr(12'h270, 16'h0081, 0);
		rd("cmd", 12'h270, 16'h0081);
		wr(12'h270, 16'h0000, 0);
		`CHK("op", 1'b1, op_mode)
		wr(12'h272, 16'h0000, 1);
		rd("timing", 12'h272, 16'h1201);
		wr(12'h270, 16'h00ec, 0);
		rd("cmd", 12'h270, 16'h006c);
		`CHK("ctl", 4'hf, {self_check, listen_only, sleep_enable, tx_pad_drive})
		gap(0, 0);
		`CHK("quantum", 4, n)
		gap(1, 2);
		`CHK("seg2", 8, n)
		gap(2, 1);
		`CHK("seg1", 16, n)
		gap(2, 2);
		`CHK("bit", 24, n)
		flags = 5'h15;
		repeat (4) @(posedge mclk);
		rd("status", 12'h271, 16'h00ac);
		node.dominant(40);
		`CHK("sample", 1'b0, sampled_bit)
		for (i = 0; i < 3; i++)
		begin
			@(posedge mclk);
			#1 evt = 3'b001 << i;
			@(posedge mclk);
			#1 evt = 0;
			`CHK("event", 1'b0, op_mode)
			rd("cmd", 12'h270, (i == 0) ? 16'h006d : 16'h0001);
			wr(12'h272, 16'h9201, 1);
			wr(12'h270, 16'h0000, 0);
		end
		repeat (30) @(posedge mclk);
		node.dominant(40);
		`CHK("triple", 1'b0, sampled_bit)
		end_of_test;
	end
endmodule
bind can_core_timing_and_mode_control
	can_core_timing_and_mode_control_asserts chk (.mclk, .srst, .reg_addr,
	.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_buffer_underflow,
	.bus_off_enter, .test_mode_enter, .op_mode, .quantum_tick,
	.sample_strobe, .bit_start);
